// ---- rtl/pldd_defs.svh ----
// Offsets, field positions, reset values and timing figures of the lock detector.
// Assumes nothing; definitions only, included by bare name.
`ifndef PLDD_DEFS_SVH
`define PLDD_DEFS_SVH

// Register byte offsets on the 10-bit register address
`define PLDD_ADDR_W 10
`define PLDD_LOCK_CFG_ADDR 10'h018
`define PLDD_SYNC_CFG_ADDR 10'h019
`define PLDD_LOCK_CFG_RST 8'h00
`define PLDD_SYNC_CFG_RST 8'h00

// Lock detect configuration fields
`define PLDD_RUN_SEL_HI 6
`define PLDD_RUN_SEL_LO 5
`define PLDD_WIN_LOW_BIT 4
`define PLDD_DISABLE_BIT 3
`define PLDD_LOCK_CFG_MASK 8'hf8

// Sync counter reset configuration fields
`define PLDD_SYNC_MODE_HI 7
`define PLDD_SYNC_MODE_LO 6

// Consecutive in-window cycle targets
`define PLDD_RUN_5 8'h05
`define PLDD_RUN_16 8'h10
`define PLDD_RUN_64 8'h40
`define PLDD_RUN_255 8'hff

// Timing, in picoseconds
`define PLDD_CLK_PERIOD_PS 100000
`define PLDD_WIN_HI_PS 3500
`define PLDD_WIN_LO_PS 2000
`define PLDD_LOSS_PS 7000

// Edge difference width, in bits; the difference itself counts clock cycles
`define PLDD_DIFF_W 8

`endif

// ---- rtl/pldd_pkg.sv ----
// Types and small helpers shared by the lock detector files.
// Assumes pldd_defs.svh is on the include path.
`include "pldd_defs.svh"

package pldd_pkg;

  // Action of the sync pin on the divider counters
  typedef enum logic [1:0] {
    PLDD_SYNC_NONE = 2'h0,
    PLDD_SYNC_ASYNC = 2'h1,
    PLDD_SYNC_SYNC = 2'h2,
    PLDD_SYNC_NONE3 = 2'h3
  } pldd_sync_mode_t;

  // One finished edge comparison
  typedef struct packed {
    logic valid;
    logic [`PLDD_DIFF_W-1:0] diff;
  } pldd_cmp_t;

  // Longest time in whole cycles: round down, never below one
  function automatic int pldd_cycles_floor(input int ps);
    int c;
    c = ps / `PLDD_CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction : pldd_cycles_floor

  // Run length selected by the two-bit counter field
  function automatic logic [7:0] pldd_run_target(input logic [1:0] sel);
    case (sel)
      2'h0: return `PLDD_RUN_5;
      2'h1: return `PLDD_RUN_16;
      2'h2: return `PLDD_RUN_64;
      default: return `PLDD_RUN_255;
    endcase
  endfunction : pldd_run_target

endpackage : pldd_pkg

// ---- rtl/pldd_edge_cmp.sv ----
// Pairs rising edges of reference and feedback and reports their distance.
// Assumes both inputs are synchronous to ref_clk; distance is in clock cycles.
`timescale 1ns/1ps

module pldd_edge_cmp
  import pldd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic refIn,
  input wire logic fbIn,
  output pldd_cmp_t cmpOut
);

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection
  logic refPrev; // Last sampled reference level
  logic fbPrev; // Last sampled feedback level
  logic refRise;
  logic fbRise;

  // Previous levels
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      refPrev <= 1'b0;
      fbPrev <= 1'b0;
    end
    else
    begin
      refPrev <= refIn;
      fbPrev <= fbIn;
    end
  end

  assign refRise = refIn && !refPrev;
  assign fbRise = fbIn && !fbPrev;

  ////////////////////////////////////////////////////////////////////////////
  // Pairing state
  typedef enum logic [2:0] {
    PLDD_IDLE = 3'b001,
    PLDD_WAIT_FB = 3'b010,
    PLDD_WAIT_REF = 3'b100
  } pldd_cmp_state_t;

  pldd_cmp_state_t state; // Which edge is still awaited
  logic [`PLDD_DIFF_W-1:0] gap; // Cycles since the leading edge
  localparam logic [`PLDD_DIFF_W-1:0] GAP_MAX = '1;

  // A repeated leading edge or a saturated gap ends the pair as far out
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= PLDD_IDLE;
      gap <= '0;
      cmpOut <= '0;
    end
    else
    begin
      cmpOut.valid <= 1'b0;
      case (state)
        PLDD_IDLE:
        begin
          gap <= 8'h01;
          if (refRise && fbRise)
          begin
            // Coincident edges
            cmpOut <= '{valid: 1'b1, diff: '0};
          end
          else if (refRise)
            state <= PLDD_WAIT_FB;
          else if (fbRise)
            state <= PLDD_WAIT_REF;
        end
        PLDD_WAIT_FB, PLDD_WAIT_REF:
        begin
          if ((state == PLDD_WAIT_FB) ? fbRise : refRise)
          begin
            cmpOut <= '{valid: 1'b1, diff: gap};
            state <= PLDD_IDLE;
          end
          else if (((state == PLDD_WAIT_FB) ? refRise : fbRise) || gap == GAP_MAX)
          begin
            // Partner missing: report worst distance
            cmpOut <= '{valid: 1'b1, diff: GAP_MAX};
            state <= PLDD_IDLE;
          end
          else
            gap <= gap + 8'h01;
        end
        default: state <= PLDD_IDLE;
      endcase
    end
  end

  // Coincident edges from idle give a zero distance next cycle
  chk_zero_diff: assert property (@(posedge ref_clk) disable iff (!nrst)
    (state == PLDD_IDLE && refRise && fbRise) |=> (cmpOut.valid && cmpOut.diff == '0))
    else $error("coincident edges not reported as zero distance");

endmodule : pldd_edge_cmp

// ---- rtl/pll_digital_lock_detect.sv ----
// Digital lock detector and sync-pin counter reset control of the PLL.
// Assumes reference and feedback divider outputs and the sync pin are
// synchronous to ref_clk; registers are written over the plain register port.
`timescale 1ns/1ps
`include "pldd_defs.svh"

module pll_digital_lock_detect
  import pldd_pkg::*;
#(
  parameter int WIN_LO_PS = `PLDD_WIN_LO_PS,
  parameter int LOSS_PS = `PLDD_LOSS_PS
)
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic refIn,
  input wire logic fbIn,
  input wire logic syncPinN,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [`PLDD_ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  output logic regRdValid,
  output logic lockFlag,
  output logic lockIndicatorPin,
  output logic counterRstAsync,
  output logic counterRstSync
);

  ////////////////////////////////////////////////////////////////////////////
  // Derived cycle counts
  localparam int WIN_HI_CYC = pldd_cycles_floor(`PLDD_WIN_HI_PS);
  localparam int WIN_LO_CYC = pldd_cycles_floor(WIN_LO_PS);
  localparam int LOSS_CYC = pldd_cycles_floor(LOSS_PS);
  localparam logic [`PLDD_DIFF_W-1:0] WIN_HI = WIN_HI_CYC[`PLDD_DIFF_W-1:0];
  localparam logic [`PLDD_DIFF_W-1:0] WIN_LO = WIN_LO_CYC[`PLDD_DIFF_W-1:0];
  localparam logic [`PLDD_DIFF_W-1:0] LOSS = LOSS_CYC[`PLDD_DIFF_W-1:0];

  // Counts must fit the distance and the loss point must not undercut a window
  if (LOSS_CYC >= 255 || LOSS_CYC < WIN_HI_CYC || LOSS_CYC < WIN_LO_CYC)
  begin : g_bad_counts
    $error("loss threshold out of range for the window counts");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  logic [7:0] lockCfg; // Lock detect configuration
  logic [7:0] syncCfg; // Sync counter reset configuration and path delays

  // Software writes; unused low bits of the lock word are not stored
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      lockCfg <= `PLDD_LOCK_CFG_RST;
      syncCfg <= `PLDD_SYNC_CFG_RST;
    end
    else if (regWrEn)
    begin
      if (regAddr == `PLDD_LOCK_CFG_ADDR)
        lockCfg <= regWrData & `PLDD_LOCK_CFG_MASK;
      else if (regAddr == `PLDD_SYNC_CFG_ADDR)
        syncCfg <= regWrData;
    end
  end

  // Reads answer one cycle later; unmapped offsets read zero
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      regRdData <= 8'h00;
      regRdValid <= 1'b0;
    end
    else
    begin
      regRdValid <= regRdEn;
      if (!regRdEn)
        regRdData <= 8'h00;
      else if (regAddr == `PLDD_LOCK_CFG_ADDR)
        regRdData <= lockCfg;
      else if (regAddr == `PLDD_SYNC_CFG_ADDR)
        regRdData <= syncCfg;
      else
        regRdData <= 8'h00;
    end
  end

  // Field views
  logic [1:0] runSel;
  logic winLow;
  logic detDisable;
  pldd_sync_mode_t syncMode;
  logic [7:0] runTarget;
  logic [`PLDD_DIFF_W-1:0] winCyc;

  assign runSel = lockCfg[`PLDD_RUN_SEL_HI:`PLDD_RUN_SEL_LO];
  assign winLow = lockCfg[`PLDD_WIN_LOW_BIT];
  assign detDisable = lockCfg[`PLDD_DISABLE_BIT];
  assign syncMode = pldd_sync_mode_t'(syncCfg[`PLDD_SYNC_MODE_HI:`PLDD_SYNC_MODE_LO]);
  assign runTarget = pldd_run_target(runSel);
  assign winCyc = winLow ? WIN_LO : WIN_HI;

  ////////////////////////////////////////////////////////////////////////////
  // Edge comparison
  pldd_cmp_t cmp; // Finished comparison, one-cycle valid

  pldd_edge_cmp u_edge_cmp (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .refIn(refIn),
    .fbIn(fbIn),
    .cmpOut(cmp)
  );

  logic inWin; // Strictly inside the window
  logic outLoss; // Strictly beyond the loss threshold
  assign inWin = cmp.valid && (cmp.diff < winCyc);
  assign outLoss = cmp.valid && (cmp.diff > LOSS);

  ////////////////////////////////////////////////////////////////////////////
  // Lock run counter and flag
  logic [7:0] runCount; // Consecutive in-window comparisons

  // Between window and loss point the run restarts but the flag holds
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      runCount <= 8'h00;
      lockFlag <= 1'b0;
      lockIndicatorPin <= 1'b0;
    end
    else if (detDisable)
    begin
      runCount <= 8'h00;
      lockFlag <= 1'b0;
      lockIndicatorPin <= 1'b0;
    end
    else if (inWin)
    begin
      if (runCount != 8'hff)
        runCount <= runCount + 8'h01;
      if (runCount + 8'h01 >= runTarget)
      begin
        lockFlag <= 1'b1;
        lockIndicatorPin <= 1'b1;
      end
    end
    else if (cmp.valid)
    begin
      runCount <= 8'h00;
      if (outLoss)
      begin
        lockFlag <= 1'b0;
        lockIndicatorPin <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sync pin effect on the divider counters
  logic syncPrevN; // Last sampled sync pin

  // Async mode follows the pin level; sync mode gives one pulse per assertion
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      syncPrevN <= 1'b1;
      counterRstAsync <= 1'b0;
      counterRstSync <= 1'b0;
    end
    else
    begin
      syncPrevN <= syncPinN;
      counterRstAsync <= 1'b0;
      counterRstSync <= 1'b0;
      case (syncMode)
        PLDD_SYNC_ASYNC: counterRstAsync <= !syncPinN;
        PLDD_SYNC_SYNC: counterRstSync <= !syncPinN && syncPrevN;
        PLDD_SYNC_NONE3: ;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence s_inwin;
    inWin && !detDisable;
  endsequence

  sequence s_run_done;
    s_inwin ##0 (runCount + 8'h01 >= runTarget);
  endsequence

  chk_lock_after_run: assert property (
    $rose(lockFlag) |-> $past(inWin) && $past(runCount + 8'h01 >= runTarget))
    else $error("lock set without a full run");
  chk_run_sets_lock: assert property (s_run_done |=> lockFlag)
    else $error("full run did not set lock");
  chk_outside_no_lock: assert property (
    (cmp.valid && cmp.diff >= winCyc && !lockFlag) |=> !lockFlag)
    else $error("lock set outside the window");
  chk_loss_clears: assert property (
    (outLoss && !detDisable) |=> !lockFlag && runCount == 8'h00)
    else $error("loss of lock not taken");
  chk_hold_between: assert property (
    (lockFlag && !detDisable && !outLoss) |=> lockFlag)
    else $error("lock dropped without loss");
  // Every finished comparison is judged against the range the bit selects
  chk_window_pick: assert property (
    cmp.valid |-> (inWin == (cmp.diff < (winLow ? WIN_LO : WIN_HI))))
    else $error("wrong window range");
  chk_disable_off: assert property (
    detDisable |=> !lockFlag && runCount == 8'h00)
    else $error("disabled detector still counting");
  chk_async_level: assert property (
    (syncMode == PLDD_SYNC_ASYNC && !syncPinN) |=> counterRstAsync)
    else $error("async counter reset missing");
  chk_sync_pulse: assert property (
    (syncMode == PLDD_SYNC_SYNC && !syncPinN && syncPrevN)
      |=> counterRstSync ##1 !counterRstSync)
    else $error("sync counter reset not one pulse");
  chk_mode3_quiet: assert property (
    (syncMode == PLDD_SYNC_NONE3 || syncMode == PLDD_SYNC_NONE)
      |=> !counterRstAsync && !counterRstSync)
    else $error("counter reset in a no-action mode");
  chk_pin_follows: assert property (lockIndicatorPin == lockFlag)
    else $error("indicator pin differs from lock flag");

endmodule : pll_digital_lock_detect

// ---- tb/pldd_partner.sv ----
// Model of the reference and feedback divider outputs feeding the detector.
// Assumes the bench changes run and lag with nonblocking writes.
`timescale 1ns/1ps

module pldd_partner
(
  input wire logic ref_clk,
  input wire logic run,
  input wire logic [2:0] lag,
  output logic refIn,
  output logic fbIn
);
  // Phase within the 8-cycle divider period
  logic [2:0] ph;

  // Quiet dividers until the first frame starts
  initial
  begin
    ph = 3'h0;
    refIn = 1'b0;
    fbIn = 1'b0;
  end

  // Changes at the falling edge, away from the sampling edge
  // Both stop low together so no edge is left unpaired
  always @(negedge ref_clk)
  begin
    ph <= run ? ph + 3'h1 : 3'h0;
    refIn <= run && (ph < 3'h4);
    fbIn <= run && (3'(ph - lag) < 3'h4);
  end
endmodule : pldd_partner

// ---- tb/tb_pll_digital_lock_detect.sv ----
// Self-checking bench of the lock detector with a divider partner model.
// Assumes the design files and pldd_partner are compiled before this one.
`timescale 1ns/1ps
`include "pldd_defs.svh"

module tb_pll_digital_lock_detect;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic syncPinN = 1'b1;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic [`PLDD_ADDR_W-1:0] regAddr = 10'h000;
  logic [7:0] regWrData = 8'h00;
  logic [7:0] regRdData;
  logic regRdValid, lockFlag, lockIndicatorPin, counterRstAsync, counterRstSync;
  logic run = 1'b0;
  logic [2:0] lag = 3'h0;
  logic refIn, fbIn;
  // Expected read data, oldest first
  logic [7:0] expQ[$];
  // Run lengths per counter select code
  int tgt[4] = '{5, 16, 64, 255};
  int err_total = 0;
  int check_count = 0;

  ////////////////////////////////////////////////////////////////////////
  // 100 ns comparison clock
  initial
    forever #50 ref_clk = ~ref_clk;

  pll_digital_lock_detect dut (.ref_clk(ref_clk), .nrst(nrst), .refIn(refIn),
    .fbIn(fbIn), .syncPinN(syncPinN), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .regRdValid(regRdValid), .lockFlag(lockFlag),
    .lockIndicatorPin(lockIndicatorPin), .counterRstAsync(counterRstAsync),
    .counterRstSync(counterRstSync));

  pldd_partner divs (.ref_clk(ref_clk), .run(run), .lag(lag), .refIn(refIn),
    .fbIn(fbIn));

  ////////////////////////////////////////////////////////////////////////
  // One comparison, reported at once on mismatch
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      err_total++;
    end
  endtask : chk

  // Flag and its pin must agree with the expectation
  task automatic flag(input logic e);
    chk("lockFlag", {7'h0, e}, {7'h0, lockFlag});
    chk("lockIndicatorPin", {7'h0, e}, {7'h0, lockIndicatorPin});
  endtask : flag

  // Strobe held one cycle, then one idle cycle so it never re-rises at once
  task automatic wr(input logic [`PLDD_ADDR_W-1:0] a, input logic [7:0] d);
    regWrEn = 1'b1;
    regAddr = a;
    regWrData = d;
    @(negedge ref_clk);
    regWrEn = 1'b0;
    @(negedge ref_clk);
  endtask : wr

  // Read: note the expectation, the monitor compares
  task automatic rd(input logic [`PLDD_ADDR_W-1:0] a, input logic [7:0] e);
    expQ.push_back(e);
    regRdEn = 1'b1;
    regAddr = a;
    @(negedge ref_clk);
    regRdEn = 1'b0;
    @(negedge ref_clk);
  endtask : rd

  // Run n divider periods at the given lag, then idle one period
  task automatic seq(input logic [2:0] l, input int n);
    lag <= l;
    run <= 1'b1;
    repeat (n * 8) @(negedge ref_clk);
    run <= 1'b0;
    repeat (8) @(negedge ref_clk);
  endtask : seq

  // Verdict and end of run
  task automatic results();
    // A read whose answer never came is a mismatch too
    chk("pendingReads", 8'h00, 8'(expQ.size()));
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  ////////////////////////////////////////////////////////////////////////
  // Read monitor: a valid with no note pending is itself a mismatch
  always @(negedge ref_clk)
    if (regRdValid === 1'b1)
    begin
      if (expQ.size() == 0)
        chk("unexpectedRead", 8'h00, 8'h01);
      else
        chk("regRdData", expQ.pop_front(), regRdData);
    end

  // Watchdog well beyond the expected run of about 3300 cycles
  initial
  begin
    #(100 * 20000);
    err_total++;
    results();
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    logic [7:0] cfg;
    int pulses;
    void'($urandom(32'h6295));
    repeat (10) @(negedge ref_clk);
    nrst = 1'b1;
    @(negedge ref_clk);
    flag(1'b0);
    rd(`PLDD_LOCK_CFG_ADDR, 8'h00);
    rd(`PLDD_SYNC_CFG_ADDR, 8'h00);
    wr(10'h01a, 8'h5a);
    rd(10'h01a, 8'h00);
    wr(`PLDD_LOCK_CFG_ADDR, 8'hff);
    rd(`PLDD_LOCK_CFG_ADDR, 8'hf8);
    $display("test registers done");
    // Every run select, random window range, then hysteresis and loss
    for (int s = 0; s < 4; s++)
    begin
      cfg = {1'b0, 2'(s), 1'($urandom), 4'h0};
      wr(`PLDD_LOCK_CFG_ADDR, cfg);
      rd(`PLDD_LOCK_CFG_ADDR, cfg);
      seq(3'h0, tgt[s] - 1);
      flag(1'b0);
      seq(3'h0, 1);
      flag(1'b1);
      seq(3'h1, 3);
      flag(1'b1);
      seq(3'h2, 1);
      flag(1'b0);
    end
    $display("test lock runs done");
    wr(`PLDD_LOCK_CFG_ADDR, 8'h00);
    seq(3'h0, 5);
    flag(1'b1);
    wr(`PLDD_LOCK_CFG_ADDR, 8'h08);
    repeat (2) @(negedge ref_clk);
    flag(1'b0);
    seq(3'h0, 5);
    flag(1'b0);
    wr(`PLDD_LOCK_CFG_ADDR, 8'h00);
    seq(3'h0, 4);
    flag(1'b0);
    seq(3'h0, 1);
    flag(1'b1);
    $display("test disable done");
    // Every sync mode with random stored low bits
    for (int m = 0; m < 4; m++)
    begin
      cfg = {2'(m), 6'($urandom)};
      wr(`PLDD_SYNC_CFG_ADDR, cfg);
      rd(`PLDD_SYNC_CFG_ADDR, cfg);
      pulses = 0;
      syncPinN = 1'b0;
      repeat (4)
      begin
        @(negedge ref_clk);
        pulses += (counterRstSync === 1'b1);
      end
      chk("counterRstSync", (m == 2) ? 8'h01 : 8'h00, 8'(pulses));
      chk("counterRstAsync", {7'h0, m == 1}, {7'h0, counterRstAsync});
      syncPinN = 1'b1;
      repeat (4) @(negedge ref_clk);
      chk("counterRstAsync", 8'h00, {7'h0, counterRstAsync});
    end
    $display("test sync modes done");
    // Mid-run reset while locked clears the flag and both registers
    nrst = 1'b0;
    repeat (2) @(negedge ref_clk);
    flag(1'b0);
    nrst = 1'b1;
    @(negedge ref_clk);
    flag(1'b0);
    rd(`PLDD_LOCK_CFG_ADDR, 8'h00);
    rd(`PLDD_SYNC_CFG_ADDR, 8'h00);
    seq(3'h0, 5);
    flag(1'b1);
    $display("test reset done");
    results();
  end
endmodule : tb_pll_digital_lock_detect
